// ---- design/kwd_pkg.sv ----
// package: register map, keys, field layout and timing counts of the keyed watchdog
package kwd_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_ACTION   = 8'h00;
    localparam logic [7:0]  OFS_TICK     = 8'h04;
    localparam logic [7:0]  OFS_RESTART  = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------------
    // keys and field positions
    // ------------------------------------------------------------------
    localparam logic [11:0] ACTION_KEY    = 12'h234;
    localparam int          ACTION_KEY_LO = 4;
    localparam int          ACTION_KEY_HI = 15;
    localparam logic [8:0]  TICK_KEY      = 9'h06e;
    localparam int          TICK_KEY_LO   = 7;
    localparam int          TICK_KEY_HI   = 15;
    localparam logic [15:0] RESTART_CODE  = 16'hc071;
    localparam int          SEL_LO        = 0;
    localparam int          SEL_HI        = 1;
    localparam int          HPC_LO        = 2;
    localparam int          HPC_HI        = 5;
    localparam logic [11:0] PRELOAD_LOW   = 12'hfff;

    // ------------------------------------------------------------------
    // divider terminal counts and pin pulse length
    // ------------------------------------------------------------------
    localparam int          PRESC_W       = 10;
    localparam logic [9:0]  DIV8_LAST     = 10'h007;
    localparam logic [9:0]  DIV32_LAST    = 10'h01f;
    localparam logic [9:0]  DIV128_LAST   = 10'h07f;
    localparam logic [9:0]  DIV1024_LAST  = 10'h3ff;
    localparam logic [3:0]  PIN_LOW_CYCLES = 4'h8;

    // ------------------------------------------------------------------
    // reset values and event bits
    // ------------------------------------------------------------------
    localparam logic [15:0] COUNT_RESET   = 16'h0fff;
    localparam int          EVT_OVERFLOW  = 0;
    localparam int          EVT_BAD_KEY   = 1;
    localparam int          EVT_W         = 2;

    typedef struct packed {
        logic ext;
        logic irq;
        logic rst;
        logic en;
    } kwd_action_s;

    typedef struct packed {
        logic [3:0] hpc;
        logic [1:0] sel;
    } kwd_tick_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } kwd_bus_s;

    localparam kwd_action_s ACTION_RESET = '{ext: 1'b0, irq: 1'b0, rst: 1'b0, en: 1'b0};
    localparam kwd_tick_s   TICK_RESET   = '{hpc: 4'h0, sel: 2'h0};

endpackage

// ---- design/kwd_watchdog.sv ----
// keyed watchdog timer: register slave, prescaler, down counter and overflow actions
//
// Notes on behaviour
// RQ1: overflow while enabled with reset action set pulses the system reset output.
// RQ2: overflow while enabled with interrupt action set emits one interrupt pulse.
// RQ3: overflow while enabled with pin action set drives pin low eight cycles.
// RQ4: restart loads counter with preload field on top and all ones below.
// RQ5: counter ticks at clock divided by 8, 32, 128 or 1024 per select.
// RQ6: action register written only when bits 15:4 carry its key; key reads zero.
// RQ7: tick register written only when bits 15:7 carry its key; key reads zero.
// RQ8: only the restart code written to the restart register restarts the counter.
// RQ9: with enable clear no overflow output of any kind is produced.
// RQ10: overflow flag sets on overflow, clears on restart or reset.
// RQ11: after reset block is disabled and config and status registers read zero.
// RQ12: software disables, programs tick, restarts, then enables with keyed writes.
// RQ13: counter decrements once per tick while enabled; wrap below zero is overflow.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module kwd_watchdog
    import kwd_pkg::*;
(
    input  wire logic     clk,                  // 10 MHz system clock
    input  wire logic     sys_rst,              // asynchronous reset, active high
    input  wire kwd_bus_s bus,                  // register request
    output logic [31:0]   rdata,                // read data, cycle after read strobe
    output logic          overflow_system_reset,// one-cycle internal reset request
    output logic          overflow_irq_pulse,   // one-cycle pulse to interrupt controller
    output logic          overflow_pin_n,       // active-low overflow pin
    output logic          irq                   // level interrupt, unmasked sticky event
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    kwd_action_s        act_q;
    kwd_tick_s          tick_q;
    logic [15:0]        cnt_q;
    logic [PRESC_W-1:0] presc_q;
    logic               flag_q;
    logic               sys_rst_q;
    logic               irqp_q;
    logic               pin_n_q;
    logic [3:0]         pin_cnt_q;
    logic [EVT_W-1:0]   ist_q;
    logic [EVT_W-1:0]   imask_q;
    logic [31:0]        rdata_q;

    typedef enum logic [2:0] {
        KWD_ST_IDLE  = 3'b001,
        KWD_ST_COUNT = 3'b010,
        KWD_ST_PULSE = 3'b100
    } kwd_pin_e;
    kwd_pin_e           pin_st_q;

    function automatic logic [PRESC_W-1:0] div_last(input logic [1:0] sel);
        case (sel)
            2'h0:    div_last = DIV8_LAST;
            2'h1:    div_last = DIV32_LAST;
            2'h2:    div_last = DIV128_LAST;
            default: div_last = DIV1024_LAST;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic wr_action;
    logic wr_tick;
    logic act_key_ok;
    logic tick_key_ok;
    logic restart;
    logic tick;
    logic ovf_evt;
    logic [EVT_W-1:0] evt;

    assign wr_action   = bus.wr && (bus.addr == OFS_ACTION);
    assign wr_tick     = bus.wr && (bus.addr == OFS_TICK);
    assign act_key_ok  = bus.wdata[ACTION_KEY_HI:ACTION_KEY_LO] == ACTION_KEY;
    assign tick_key_ok = bus.wdata[TICK_KEY_HI:TICK_KEY_LO] == TICK_KEY;
    assign restart     = bus.wr && (bus.addr == OFS_RESTART)
                         && (bus.wdata[15:0] == RESTART_CODE);   // [RQ8]
    // prescaler stands still while disabled, so after enable it resumes the partly elapsed period
    assign tick        = act_q.en && (presc_q == div_last(tick_q.sel));   // [RQ5]
    assign ovf_evt     = tick && !restart && (cnt_q == 16'h0000);         // [RQ13] [RQ9]
    assign evt[EVT_OVERFLOW] = ovf_evt;
    assign evt[EVT_BAD_KEY]  = (wr_action && !act_key_ok) || (wr_tick && !tick_key_ok);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            act_q <= ACTION_RESET;                                      // [RQ11]
        else if (wr_action && act_key_ok)
            act_q <= kwd_action_s'(bus.wdata[3:0]);                     // [RQ6]
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tick_q <= TICK_RESET;                                       // [RQ11]
        else if (wr_tick && tick_key_ok)
            tick_q <= kwd_tick_s'(bus.wdata[HPC_HI:SEL_LO]);            // [RQ7]
    end

    // ------------------------------------------------------------------
    // prescaler and down counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            presc_q <= '0;
        else if (restart || tick)
            presc_q <= '0;                                              // [RQ5]
        else if (act_q.en)
            presc_q <= presc_q + 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= COUNT_RESET;
        else if (restart)
            cnt_q <= {tick_q.hpc, PRELOAD_LOW};                         // [RQ4]
        else if (tick)
            cnt_q <= cnt_q - 1'b1;                                      // [RQ13]
    end

    // restart masks a coincident overflow in ovf_evt, so the set and the restart clear never meet
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flag_q <= 1'b0;
        else if (ovf_evt)
            flag_q <= 1'b1;                                             // [RQ10]
        else if (restart)
            flag_q <= 1'b0;                                             // [RQ10]
    end

    // ------------------------------------------------------------------
    // overflow actions
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sys_rst_q <= 1'b0;
            irqp_q    <= 1'b0;
        end
        else
        begin
            sys_rst_q <= ovf_evt && act_q.rst;                          // [RQ1]
            irqp_q    <= ovf_evt && act_q.irq;                          // [RQ2]
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_st_q  <= KWD_ST_IDLE;
            pin_n_q   <= 1'b1;
            pin_cnt_q <= '0;
        end
        else
        begin
            case (pin_st_q)
                KWD_ST_IDLE:
                begin
                    if (ovf_evt && act_q.ext)
                    begin
                        pin_st_q  <= KWD_ST_COUNT;
                        pin_n_q   <= 1'b0;                              // [RQ3]
                        pin_cnt_q <= PIN_LOW_CYCLES - 4'h1;
                    end
                end
                KWD_ST_COUNT:
                begin
                    if (pin_cnt_q == 4'h1)
                        pin_st_q <= KWD_ST_PULSE;
                    pin_cnt_q <= pin_cnt_q - 4'h1;
                end
                KWD_ST_PULSE:
                begin
                    pin_st_q <= KWD_ST_IDLE;
                    pin_n_q  <= 1'b1;                                   // [RQ3]
                end
                default:
                begin
                    pin_st_q <= KWD_ST_IDLE;
                    pin_n_q  <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // event status, mask and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ist_q <= '0;
        else if (bus.wr && (bus.addr == OFS_IRQ_STAT))
            ist_q <= (ist_q & ~bus.wdata[EVT_W-1:0]) | evt;
        else
            ist_q <= ist_q | evt;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            imask_q <= '0;
        else if (bus.wr && (bus.addr == OFS_IRQ_MASK))
            imask_q <= bus.wdata[EVT_W-1:0];
    end

    // ------------------------------------------------------------------
    // read path: keys and the restart register read as zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_q <= '0;
        else if (bus.rd)
        begin
            case (bus.addr)
                OFS_ACTION:   rdata_q <= {28'h0000000, act_q};          // [RQ6]
                OFS_TICK:     rdata_q <= {26'h0, tick_q};               // [RQ7]
                OFS_STATUS:   rdata_q <= {31'h0, flag_q};               // [RQ10]
                OFS_IRQ_STAT: rdata_q <= {30'h0, ist_q};
                OFS_IRQ_MASK: rdata_q <= {30'h0, imask_q};
                default:      rdata_q <= '0;
            endcase
        end
        else
            rdata_q <= '0;
    end

    assign rdata                 = rdata_q;
    assign overflow_system_reset = sys_rst_q;
    assign overflow_irq_pulse    = irqp_q;
    assign overflow_pin_n        = pin_n_q;
    assign irq                   = |(ist_q & imask_q);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_RESET_ON_OVF: assert property (                                 // [RQ1]
        ovf_evt && act_q.rst |=> overflow_system_reset)
        else $error("reset action missing after overflow");
    AST_RESET_ONLY_OVF: assert property (                               // [RQ1]
        overflow_system_reset |-> $past(ovf_evt) && $past(act_q.rst))
        else $error("reset pulse without cause");
    AST_IRQ_SINGLE: assert property (                                   // [RQ2]
        overflow_irq_pulse |-> $past(ovf_evt && act_q.irq) ##1 !overflow_irq_pulse)
        else $error("interrupt pulse not single or without cause");
    AST_PIN_EIGHT: assert property (                                    // [RQ3]
        $fell(overflow_pin_n) |-> !overflow_pin_n [*8] ##1 overflow_pin_n)
        else $error("overflow pin low length wrong");
    AST_PRELOAD: assert property (                                      // [RQ4]
        restart |=> cnt_q == {$past(tick_q.hpc), PRELOAD_LOW})
        else $error("restart preload wrong");
    // restart, disable or a config write inside the period legally moves the next tick
    AST_TICK_SPACING: assert property (                                 // [RQ5]
        tick && tick_q.sel == 2'h0 && !wr_tick
        ##1 (act_q.en && !restart && !wr_tick && !wr_action) [*7]
        |-> !tick ##1 tick)
        else $error("divide by eight spacing wrong");
    AST_ACT_KEY: assert property (                                      // [RQ6]
        wr_action && !act_key_ok |=> $stable(act_q))
        else $error("unkeyed action write took effect");
    AST_TICK_KEY: assert property (                                     // [RQ7]
        wr_tick && !tick_key_ok |=> $stable(tick_q))
        else $error("unkeyed tick write took effect");
    AST_DISABLED_QUIET: assert property (                               // [RQ9]
        !act_q.en |=> !overflow_system_reset && !overflow_irq_pulse && !$fell(overflow_pin_n))
        else $error("overflow output while disabled");
    AST_FLAG: assert property (                                         // [RQ10]
        (ovf_evt |=> flag_q) and (restart && !ovf_evt |=> !flag_q))
        else $error("overflow flag wrong");
    AST_DECREMENT: assert property (                                    // [RQ13]
        tick && !restart |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("counter did not decrement on tick");

    // ------------------------------------------------------------------
    // register and output checks
    // ------------------------------------------------------------------
    AST_RESET_SINGLE: assert property (                                 // [RQ1]
        overflow_system_reset |=> !overflow_system_reset)
        else $error("reset pulse longer than one cycle");
    AST_IRQ_ON_OVF: assert property (                                   // [RQ2]
        ovf_evt && act_q.irq |=> overflow_irq_pulse)
        else $error("interrupt pulse missing after overflow");
    AST_PIN_ON_OVF: assert property (                                   // [RQ3]
        ovf_evt && act_q.ext && pin_st_q == KWD_ST_IDLE |=> !overflow_pin_n)
        else $error("overflow pin not driven low");
    AST_PIN_CAUSE: assert property (                                    // [RQ3]
        $fell(overflow_pin_n) |-> $past(ovf_evt && act_q.ext))
        else $error("overflow pin low without cause");
    AST_ACT_WRITE: assert property (                                    // [RQ6]
        wr_action && act_key_ok |=> act_q == kwd_action_s'($past(bus.wdata[3:0])))
        else $error("keyed action write lost");
    AST_KEY_READS_ZERO: assert property (                               // [RQ6] [RQ7]
        bus.rd && (bus.addr == OFS_ACTION || bus.addr == OFS_TICK) |=> rdata[31:6] == 26'h0)
        else $error("key field read back nonzero");
    AST_RESTART_ONLY_CODE: assert property (                            // [RQ8]
        bus.wr && bus.addr == OFS_RESTART && bus.wdata[15:0] != RESTART_CODE && !tick
        |=> $stable(cnt_q))
        else $error("wrong restart code moved the counter");
    AST_DISABLED_FROZEN: assert property (                              // [RQ5] [RQ9]
        !act_q.en && !restart |=> $stable(presc_q) && $stable(cnt_q))
        else $error("counting while disabled");
    AST_STATUS_READ: assert property (                                  // [RQ10]
        bus.rd && bus.addr == OFS_STATUS |=> rdata == {31'h0, $past(flag_q)})
        else $error("status read wrong");
    AST_FLAG_HOLD: assert property (                                    // [RQ10]
        flag_q && !restart |=> flag_q)
        else $error("overflow flag lost without restart");
    AST_HOLD_NO_TICK: assert property (                                 // [RQ13]
        !tick && !restart |=> $stable(cnt_q))
        else $error("counter moved without tick");
    AST_OVF_WRAP: assert property (                                     // [RQ13]
        ovf_evt |=> cnt_q == 16'hffff)
        else $error("counter did not wrap on overflow");
    AST_RDATA_IDLE: assert property (
        !bus.rd |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    AST_BAD_KEY_EVT: assert property (
        evt[EVT_BAD_KEY] |=> ist_q[EVT_BAD_KEY])
        else $error("rejected key write not recorded");
    AST_PIN_ONE_HOT: assert property (
        $onehot(pin_st_q))
        else $error("pin state not one-hot");

    CVR_OVERFLOW_RESET: cover property (overflow_system_reset);
    CVR_PIN_PULSE: cover property ($rose(overflow_pin_n));
    CVR_RESTART_ENABLED: cover property (restart && act_q.en);
    CVR_BAD_KEY: cover property (evt[EVT_BAD_KEY]);
    CVR_IRQ_PULSE: cover property (overflow_irq_pulse);

endmodule

`default_nettype wire

// ---- testbench/kwd_watchdog_tb.sv ----
// self-checking testbench for the keyed watchdog timer
`timescale 1ns/1ps
`default_nettype none

module kwd_watchdog_tb;
    import kwd_pkg::*;

    // ------------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------------
    logic        clk;
    logic        sys_rst;
    kwd_bus_s    bus;
    logic [31:0] rdata;
    logic        overflow_system_reset;
    logic        overflow_irq_pulse;
    logic        overflow_pin_n;
    logic        irq;
    logic [31:0] rv;
    logic [31:0] d;
    logic [31:0] act_m;
    logic [31:0] tick_m;
    logic        bad_key;
    int          num_errors;
    int          num_checks;
    int          cyc;
    int          n_rst;
    int          n_irq;
    int          n_pin;
    int          t_rst;
    int          t_irq;
    int          t_pin;
    int          t0;

    kwd_watchdog kwd_watchdog_inst (
        .clk                   (clk),
        .sys_rst               (sys_rst),
        .bus                   (bus),
        .rdata                 (rdata),
        .overflow_system_reset (overflow_system_reset),
        .overflow_irq_pulse    (overflow_irq_pulse),
        .overflow_pin_n        (overflow_pin_n),
        .irq                   (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // counts output activity; first occurrence times give the overflow moment
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (overflow_irq_pulse === 1'b1)
        begin
            if (n_irq == 0) t_irq = cyc;
            n_irq = n_irq + 1;
        end
        if (overflow_system_reset === 1'b1)
        begin
            if (n_rst == 0) t_rst = cyc;
            n_rst = n_rst + 1;
        end
        if (overflow_pin_n === 1'b0)
        begin
            if (n_pin == 0) t_pin = cyc;
            n_pin = n_pin + 1;
        end
    end

    // ------------------------------------------------------------------
    // tasks and expectation functions
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // an idle edge after each strobe keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus.addr  <= a;
        bus.wdata <= wd;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd   <= 1'b0;
        @(posedge clk);
        q = rdata;
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [31:0] exp_act(input logic [31:0] wd, input logic [31:0] old);
        return (wd[15:4] == ACTION_KEY) ? {28'h0, wd[3:0]} : old;
    endfunction

    function automatic logic [31:0] exp_tick(input logic [31:0] wd, input logic [31:0] old);
        return (wd[15:7] == TICK_KEY) ? {26'h0, wd[5:0]} : old;
    endfunction

    // divide by 8, high preload 0: overflow lands 4096 enabled ticks after enable;
    // a pause near the end shows that a disabled counter neither runs nor fires
    task automatic run_ovf(input logic [31:0] act, input logic by_reset);
        int lim;
        int tp;
        wr(OFS_ACTION, 32'h0000_2340);
        wr(OFS_TICK, 32'h0000_3700);
        wr(OFS_RESTART, {16'h0, RESTART_CODE});
        n_rst = 0;
        n_irq = 0;
        n_pin = 0;
        wr(OFS_ACTION, act);
        t0 = cyc;
        repeat (32000) @(posedge clk);
        wr(OFS_ACTION, {act[31:1], 1'b0});
        tp = cyc;
        repeat (2000) @(posedge clk);
        check(n_rst + n_irq + n_pin, 32'h0);
        wr(OFS_ACTION, act);
        t0 = t0 + cyc - tp;
        d = $urandom;
        if (d[15:0] == RESTART_CODE) d[0] = ~d[0];
        wr(OFS_RESTART, d);
        lim = 0;
        while (n_irq + n_rst + n_pin == 0 && lim < 40000)
        begin
            @(posedge clk);
            lim = lim + 1;
        end
        if (lim >= 40000)
        begin
            num_errors = num_errors + 1;
            end_sim();
        end
        repeat (12) @(posedge clk);
        check(n_rst, {31'h0, act[1]});
        check(n_irq, {31'h0, act[2]});
        check(n_pin, act[3] ? 32'h8 : 32'h0);
        check(t_irq - t0 >= 32764 && t_irq - t0 <= 32772, 1'b1);
        if (act[1]) check(t_rst, t_irq);
        if (act[3]) check(t_pin, t_irq);
        rd(OFS_STATUS, rv);
        check(rv, 32'h1);
        check(irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'h1);
        check(irq, 1'b0);
        if (by_reset) do_reset();
        else wr(OFS_RESTART, {16'h0, RESTART_CODE});
        rd(OFS_STATUS, rv);
        check(rv, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        bus     = '0;
        void'($urandom(32'ha057d469));
        do_reset();
        check(overflow_pin_n, 1'b1);
        foreach (rv[i]) if (i < 6)
        begin
            rd(8'(i * 4), d);
            check(d, 32'h0);
        end
        rd(8'h18, rv);
        check(rv, 32'h0);
        act_m   = 32'h0;
        tick_m  = 32'h0;
        bad_key = 1'b0;
        for (int k = 0; k < 16; k++)
        begin
            d = $urandom;
            if (d[31]) d[15:4] = ACTION_KEY;
            d[0] = 1'b0;
            if (k[0])
            begin
                if (d[30]) d[15:7] = TICK_KEY;
                bad_key = bad_key | (d[15:7] != TICK_KEY);
                tick_m  = exp_tick(d, tick_m);
                wr(OFS_TICK, d);
                rd(OFS_TICK, rv);
                check(rv, tick_m);
            end
            else
            begin
                bad_key = bad_key | (d[15:4] != ACTION_KEY);
                act_m   = exp_act(d, act_m);
                wr(OFS_ACTION, d);
                rd(OFS_ACTION, rv);
                check(rv, act_m);
            end
        end
        rd(OFS_IRQ_STAT, rv);
        check(rv, {30'h0, bad_key, 1'b0});
        wr(OFS_IRQ_MASK, 32'h2);
        check(irq, bad_key);
        wr(OFS_IRQ_STAT, 32'h2);
        check(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h1);
        run_ovf(32'h0000_234f, 1'b0);
        run_ovf(32'h0000_2345, 1'b1);
        rd(OFS_ACTION, rv);
        check(rv, 32'h0);
        rd(OFS_TICK, rv);
        check(rv, 32'h0);
        wr(OFS_ACTION, 32'h0000_234e);
        wr(OFS_RESTART, {16'h0, RESTART_CODE});
        n_rst = 0;
        n_irq = 0;
        n_pin = 0;
        repeat (2000) @(posedge clk);
        check(n_rst + n_irq + n_pin, 32'h0);
        end_sim();
    end

endmodule

`default_nettype wire
